// >>> hdl/vir_core.sv
// Vectored interrupt response logic with Wishbone register slave
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "vir_defines.svh"
// Function
// - Level 0 ranks just below non-maskable
// - Sample level 0 at final sample point
// - Level 0 masked by global or enable
// - Mode chosen by set-mode, reset mode 0
// - Mode 0 latches instruction, no push
// - Undefined mode-0 instruction raises trap
// - Mode 1 pushes, clears flags, jumps 0038H
// - Table of two-byte entries, low first
// - Table page from vector page register
// - Mode 2 latches low vector byte
// - Vector fetch strobes low, two waits
// - Vector page cleared on reset
// - Fixed sources use low-vector upper bits
// - Fixed codes and priority order
// - Level 1/2 global and individual masks
// - Sample level 1/2 at final point
// - Low-vector bits set 32-byte sub-boundary
// - Reset clears flags, level1/2, sets level0
// - Enable op sets global mask flag
// - Peripheral enables gated, cleared on reset
// - Taking interrupt clears both mask flags
module vir_core
  import vir_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sample_pt,
  input  wire logic        nmi_pending,
  input  wire logic        level0_request_n,
  input  wire logic        level1_request_n,
  input  wire logic        level2_request_n,
  input  wire logic [6:0]  periph_req,
  input  wire logic        t3_rise,
  input  wire logic [7:0]  data_in,
  input  wire logic        undefined_op,
  input  wire logic        resp_taken,
  output logic             opcode_fetch_strobe_n,
  output logic             io_request_strobe_n,
  output logic             auto_wait_state,
  output vir_resp_s        resp
);

  vir_state_s s_reg;
  vir_state_s s_next;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Fixed five-bit code of a source index, level1 first
  function automatic logic [4:0] vir_code(input logic [3:0] idx);
    vir_code = {idx[3:0], 1'b0};
  endfunction : vir_code

  function automatic logic vir_hit(input logic [5:0] adr,
                                   input logic [3:0] idx);
    vir_hit = (adr[5:2] == idx);
  endfunction : vir_hit

  // ------------------------------------------------------------
  // Request gathering
  // ------------------------------------------------------------
  logic [`VIR_NSRC-1:0] fixed_req;
  logic                 l0_live;
  logic [3:0]           win_idx;
  logic                 win_any;

  assign fixed_req[0] = ~level1_request_n & s_reg.interrupt_trap_control[`VIR_BIT_L1EN];
  assign fixed_req[1] = ~level2_request_n & s_reg.interrupt_trap_control[`VIR_BIT_L2EN];

  genvar g;
  generate
    for (g = 0; g < `VIR_NPERIPH; g = g + 1) begin : g_per
      assign fixed_req[g+2] = periph_req[g] & s_reg.periph_en[g];
    end
  endgenerate

  assign l0_live = ~level0_request_n & s_reg.interrupt_trap_control[`VIR_BIT_L0EN];

  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int i = `VIR_NSRC - 1; i >= 0; i--) begin
      if (fixed_req[i]) begin
        win_idx = i[3:0];
        win_any = 1'b1;
      end
    end
  end

  logic wb_req;
  logic wb_wr;
  logic [7:0] wdat;
  assign wb_req = wb_cyc_i & wb_stb_i & ~s_reg.wb.ack;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  assign wdat   = wb_dat_i[7:0];

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.wb.ack = wb_req;
    s_next.resp.valid = s_reg.resp.valid & ~resp_taken;

    // Register reads
    if (wb_req) begin
      s_next.wb.dat = 32'h0;
      unique case (wb_adr_i[5:2])
        `VIR_ADR_CTRL:   s_next.wb.dat[2:0] = s_reg.interrupt_trap_control;
        `VIR_ADR_PAGE:   s_next.wb.dat[7:0] = s_reg.page;
        `VIR_ADR_LOWVEC: s_next.wb.dat[7:5] = s_reg.lowvec;
        `VIR_ADR_PERIPH: s_next.wb.dat[6:0] = s_reg.periph_en;
        `VIR_ADR_STATUS: s_next.wb.dat[7:0] = {s_reg.st, s_reg.mode,
                                               s_reg.resp.valid,
                                               s_reg.smask, s_reg.gmask};
        `VIR_ADR_VECTOR: s_next.wb.dat[15:0] = s_reg.resp.addr;
        default:         s_next.wb.dat = 32'h0;
      endcase
    end

    // Register writes
    if (wb_wr) begin
      if (vir_hit(wb_adr_i, `VIR_ADR_CTRL))
        s_next.interrupt_trap_control = wdat[2:0];
      if (vir_hit(wb_adr_i, `VIR_ADR_PAGE))
        s_next.page = wdat;
      if (vir_hit(wb_adr_i, `VIR_ADR_LOWVEC))
        s_next.lowvec = wdat[7:5];
      if (vir_hit(wb_adr_i, `VIR_ADR_PERIPH))
        s_next.periph_en = wdat[6:0];
      if (vir_hit(wb_adr_i, `VIR_ADR_CMD)) begin
        if (wdat[`VIR_CMD_EI]) begin
          s_next.gmask = 1'b1;
          s_next.smask = 1'b1;
        end else if (wdat[`VIR_CMD_DI]) begin
          s_next.gmask = 1'b0;
          s_next.smask = 1'b0;
        end
        if (wdat[`VIR_CMD_SETMODE] &&
            wdat[`VIR_CMD_MODE_HI:`VIR_CMD_MODE_LO] != 2'b11)
          s_next.mode = vir_mode_e'(wdat[`VIR_CMD_MODE_HI:`VIR_CMD_MODE_LO]);
      end
    end

    unique case (s_reg.st)
      VIR_IDLE: begin
        // sample at the final sample point
        if (sample_pt && s_reg.gmask && !s_reg.resp.valid) begin
          if (nmi_pending) begin
            s_next.st = VIR_IDLE;
          end else if (l0_live) begin
            s_next.gmask = 1'b0;
            s_next.smask = 1'b0;
            if (s_reg.mode == VIR_MODE1) begin
              s_next.resp.valid   = 1'b1;
              s_next.resp.kind    = VIR_KIND_RST;
              s_next.resp.push_pc = 1'b1;
              s_next.resp.addr    = `VIR_RESTART_ADDR;
              s_next.resp.trap    = 1'b0;
            end else begin
              s_next.st  = VIR_ACK;
              s_next.ext = (s_reg.mode == VIR_MODE2);
            end
          end else if (win_any) begin
            s_next.gmask = 1'b0;
            s_next.smask = 1'b0;
            // vector from page and low-vector bits
            s_next.resp.valid   = 1'b1;
            s_next.resp.kind    = VIR_KIND_VEC;
            s_next.resp.push_pc = 1'b1;
            s_next.resp.addr    = {s_reg.page, s_reg.lowvec,
                                   vir_code(win_idx)};
            s_next.resp.trap    = 1'b0;
          end
        end
      end
      VIR_ACK: begin
        // external vector fetch gets two waits
        s_next.waits = s_reg.ext ? `VIR_AUTO_WAITS : 2'h0;
        s_next.st    = s_reg.ext ? VIR_WAIT : VIR_LATCH;
      end
      VIR_WAIT: begin
        s_next.waits = s_reg.waits - 2'h1;
        if (s_reg.waits == 2'h1)
          s_next.st = VIR_LATCH;
      end
      VIR_LATCH: begin
        if (t3_rise) begin
          s_next.st = VIR_DONE;
          s_next.resp.valid = 1'b1;
          s_next.resp.trap  = 1'b0;
          if (s_reg.ext) begin
            // latch low vector byte, push, use table
            s_next.resp.kind    = VIR_KIND_VEC;
            s_next.resp.push_pc = 1'b1;
            s_next.resp.addr    = {s_reg.page, data_in};
          end else begin
            s_next.resp.kind    = VIR_KIND_INSTR;
            s_next.resp.push_pc = 1'b0;
            s_next.resp.instr   = data_in;
            s_next.resp.addr    = 16'h0;
            s_next.resp.trap    = undefined_op;
          end
        end
      end
      VIR_DONE: s_next.st = VIR_IDLE;
      default:  s_next.st = VIR_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg           <= '0;
      s_reg.st        <= VIR_IDLE;
      s_reg.mode      <= VIR_MODE0;
      s_reg.interrupt_trap_control       <= `VIR_CTRL_RESET;
      s_reg.page      <= `VIR_PAGE_RESET;
      s_reg.lowvec    <= `VIR_LOWVEC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic fetch_cyc;
  assign fetch_cyc = (s_reg.st == VIR_WAIT) || (s_reg.st == VIR_LATCH) ||
                     (s_reg.st == VIR_ACK);
  assign opcode_fetch_strobe_n = ~fetch_cyc;
  assign io_request_strobe_n   = ~fetch_cyc;
  assign auto_wait_state       = (s_reg.st == VIR_WAIT);
  assign wb_ack_o              = s_reg.wb.ack;
  assign wb_dat_o              = s_reg.wb.dat;
  assign resp                  = s_reg.resp;

endmodule : vir_core

// >>> hdl/vir_defines.svh
// Register offsets, field positions, reset values and fixed addresses
`ifndef VIR_DEFINES_SVH
`define VIR_DEFINES_SVH

// ------------------------------------------------------------
// Register word addresses (byte address = index * 4)
// ------------------------------------------------------------
`define VIR_ADR_CTRL      4'h0
`define VIR_ADR_PAGE      4'h1
`define VIR_ADR_LOWVEC    4'h2
`define VIR_ADR_PERIPH    4'h3
`define VIR_ADR_CMD       4'h4
`define VIR_ADR_STATUS    4'h5
`define VIR_ADR_VECTOR    4'h6

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define VIR_BIT_L0EN      0
`define VIR_BIT_L1EN      1
`define VIR_BIT_L2EN      2
`define VIR_CTRL_RESET    3'h1

// ------------------------------------------------------------
// Command register fields (write-only actions)
// ------------------------------------------------------------
`define VIR_CMD_EI        0
`define VIR_CMD_DI        1
`define VIR_CMD_SETMODE   2
`define VIR_CMD_MODE_LO   3
`define VIR_CMD_MODE_HI   4

// ------------------------------------------------------------
// Reset values and fixed addresses
// ------------------------------------------------------------
`define VIR_PAGE_RESET    8'h00
`define VIR_LOWVEC_RESET  3'h0
`define VIR_RESTART_ADDR  16'h0038
`define VIR_AUTO_WAITS    2'h2
`define VIR_NSRC          9
`define VIR_NPERIPH       7

`endif

// >>> hdl/vir_pkg.sv
// Types of the vectored interrupt response block
package vir_pkg;

  typedef enum logic [1:0] {
    VIR_MODE0 = 2'b00,
    VIR_MODE1 = 2'b01,
    VIR_MODE2 = 2'b10
  } vir_mode_e;

  typedef enum logic [2:0] {
    VIR_IDLE  = 3'b000,
    VIR_ACK   = 3'b001,
    VIR_WAIT  = 3'b010,
    VIR_LATCH = 3'b011,
    VIR_DONE  = 3'b100
  } vir_state_e;

  typedef enum logic [1:0] {
    VIR_KIND_INSTR = 2'b00,
    VIR_KIND_RST   = 2'b01,
    VIR_KIND_VEC   = 2'b10
  } vir_kind_e;

  // Response handed to the sequencer
  typedef struct packed {
    logic        valid;
    vir_kind_e   kind;
    logic        push_pc;
    logic [15:0] addr;
    logic [7:0]  instr;
    logic        trap;
  } vir_resp_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } vir_wb_s;

  typedef struct packed {
    vir_state_e  st;
    vir_mode_e   mode;
    logic        gmask;
    logic        smask;
    logic [2:0]  interrupt_trap_control;
    logic [7:0]  page;
    logic [2:0]  lowvec;
    logic [6:0]  periph_en;
    logic [1:0]  waits;
    logic        ext;
    logic [3:0]  src;
    vir_resp_s   resp;
    vir_wb_s     wb;
  } vir_state_s;

endpackage : vir_pkg

// >>> test/vectored_interrupt_response_bench.sv
// Self-checking bench for the vectored interrupt response block
`timescale 1ns/1ps
module vectored_interrupt_response_bench;
  import vir_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic        wb_ack_o, sample_pt = 1'b0, nmi_pending = 1'b0;
  logic        level0_request_n = 1'b1, level1_request_n = 1'b1;
  logic        level2_request_n = 1'b1;
  logic [6:0]  periph_req = 7'h00;
  logic        t3_rise, undefined_op, resp_taken = 1'b0;
  logic [7:0]  data_in, vec_byte = 8'h00;
  logic        opcode_fetch_strobe_n, io_request_strobe_n, auto_wait_state;
  logic [1:0]  delay = 2'h0;
  logic        bad = 1'b0;
  vir_resp_s   resp, g;
  int          err_total = 0, checked = 0, cycles = 0;
  logic [8:0]  rq_row [9] = '{9'h1FF, 9'h1FE, 9'h1FC, 9'h1F8, 9'h1F0,
                              9'h1E0, 9'h1C0, 9'h180, 9'h100};
  logic [4:0]  cd_row [9] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08,
                              5'h0A, 5'h0C, 5'h0E, 5'h10};

  vir_core dut (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_pt, .nmi_pending,
    .level0_request_n, .level1_request_n, .level2_request_n, .periph_req,
    .t3_rise, .data_in, .undefined_op, .resp_taken, .opcode_fetch_strobe_n,
    .io_request_strobe_n, .auto_wait_state, .resp);
  vir_dev_model peer (.ref_clk, .rstn, .fetch_n(opcode_fetch_strobe_n),
    .ioreq_n(io_request_strobe_n), .waiting(auto_wait_state), .delay,
    .vec_byte, .bad, .t3_rise, .data_out(data_in), .undef(undefined_op));

  always #2.5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic wb(input logic we, input logic [3:0] idx,
                    input logic [31:0] wd);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= wd;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic cmp_val(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] m, e);
    wb(1'b0, idx, 32'h0);
    cmp_val(r & m, e);
  endtask : rd_chk

  task automatic cmp_resp(input vir_resp_s e);
    logic [28:0] m;
    m = (e.kind === VIR_KIND_INSTR) ? 29'h1E0001FF : 29'h1FFFFE00;
    checked++;
    if (((g ^ e) & m) !== 29'h0) begin
      err_total++;
      $display("[ERR] %0t response %h expected %h", $time, g, e);
    end
  endtask : cmp_resp

  task automatic take(input logic [8:0] rq, input logic l0);
    int n;
    @(posedge ref_clk);
    level0_request_n <= !l0;
    level1_request_n <= !rq[0];
    level2_request_n <= !rq[1];
    periph_req       <= rq[8:2];
    sample_pt        <= 1'b1;
    @(posedge ref_clk);
    level0_request_n <= 1'b1;
    level1_request_n <= 1'b1;
    level2_request_n <= 1'b1;
    periph_req       <= 7'h00;
    sample_pt        <= 1'b0;
    n = 0;
    while (resp.valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    g = resp;
    resp_taken <= resp.valid;
    @(posedge ref_clk);
    resp_taken <= 1'b0;
  endtask : take

  // ------------------------------------------------------------
  // Directed sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(4'h0, 32'hFFFFFFFF, 32'h1);
    rd_chk(4'h1, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h3, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h5, 32'h1B, 32'h0);
    rd_chk(4'h7, 32'hFFFFFFFF, 32'h0);
    take(9'h000, 1'b1);
    cmp_val({31'h0, g.valid}, 32'h0);
    wb(1'b1, 4'h4, 32'h1);
    take(9'h003, 1'b0);
    cmp_val({31'h0, g.valid}, 32'h0);
    take(9'h004, 1'b0);
    cmp_val({31'h0, g.valid}, 32'h0);
    wb(1'b1, 4'h0, 32'h0);
    take(9'h000, 1'b1);
    cmp_val({31'h0, g.valid}, 32'h0);
    wb(1'b1, 4'h0, 32'h7);
    nmi_pending <= 1'b1;
    take(9'h000, 1'b1);
    cmp_val({31'h0, g.valid}, 32'h0);
    nmi_pending <= 1'b0;
    delay <= 2'h2;
    vec_byte <= 8'hC7;
    take(9'h000, 1'b1);
    cmp_resp('{1'b1, VIR_KIND_INSTR, 1'b0, 16'h0, 8'hC7, 1'b0});
    rd_chk(4'h5, 32'h3, 32'h0);
    wb(1'b1, 4'h4, 32'h1);
    bad <= 1'b1;
    take(9'h000, 1'b1);
    cmp_resp('{1'b1, VIR_KIND_INSTR, 1'b0, 16'h0, 8'hC7, 1'b1});
    bad <= 1'b0;
    wb(1'b1, 4'h4, 32'h0C);
    wb(1'b1, 4'h4, 32'h1);
    take(9'h000, 1'b1);
    cmp_resp('{1'b1, VIR_KIND_RST, 1'b1, 16'h0038, 8'h0, 1'b0});
    rd_chk(4'h5, 32'h3, 32'h0);
    wb(1'b1, 4'h4, 32'h14);
    wb(1'b1, 4'h1, 32'hA5);
    rd_chk(4'h5, 32'h1B, 32'h10);
    wb(1'b1, 4'h4, 32'h1);
    delay <= 2'h0;
    vec_byte <= 8'h3C;
    take(9'h001, 1'b1);
    cmp_resp('{1'b1, VIR_KIND_VEC, 1'b1, 16'hA53C, 8'h0, 1'b0});
    rd_chk(4'h6, 32'hFFFFFFFF, 32'hA53C);
    wb(1'b1, 4'h2, 32'hA0);
    wb(1'b1, 4'h3, 32'h7F);
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, 4'h4, 32'h1);
      take(rq_row[i], 1'b0);
      cmp_resp('{1'b1, VIR_KIND_VEC, 1'b1, {8'hA5, 3'h5, cd_row[i]},
                 8'h0, 1'b0});
    end
    // Requests that miss the sample point are never taken
    wb(1'b1, 4'h4, 32'h1);
    @(posedge ref_clk);
    level0_request_n <= 1'b0;
    level1_request_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    level0_request_n <= 1'b1;
    level1_request_n <= 1'b1;
    rd_chk(4'h5, 32'hE7, 32'h03);
    // Reset in mid-run brings control, page, low-vector, peripheral and status registers back
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(4'h0, 32'hFFFFFFFF, 32'h1);
    rd_chk(4'h1, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h3, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h5, 32'h1B, 32'h0);
    report_and_stop();
  end
endmodule : vectored_interrupt_response_bench

// >>> test/vir_core_chk.sv
// Concurrent checks on the ports of the interrupt response block
`timescale 1ns/1ps
module vir_core_chk
  import vir_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       t3_rise,
  input wire logic [7:0] data_in,
  input wire logic       undefined_op,
  input wire logic       resp_taken,
  input wire logic       opcode_fetch_strobe_n,
  input wire logic       io_request_strobe_n,
  input wire logic       auto_wait_state,
  input wire vir_resp_s  resp
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered in one cycle");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack held longer than one cycle");
  property p_strb;
    opcode_fetch_strobe_n == io_request_strobe_n;
  endproperty
  a_strb: assert property (p_strb)
    else $error("fetch and io strobes disagree");
  property p_wait2;
    $rose(auto_wait_state) |-> auto_wait_state [*2] ##1 !auto_wait_state;
  endproperty
  a_wait2: assert property (p_wait2)
    else $error("wait run is not two cycles");
  property p_wait_ack;
    $rose(auto_wait_state) |-> !$past(opcode_fetch_strobe_n)
      && !io_request_strobe_n;
  endproperty
  a_wait_ack: assert property (p_wait_ack)
    else $error("wait outside acknowledge");
  property p_instr;
    $rose(resp.valid) && resp.kind == VIR_KIND_INSTR |-> $past(t3_rise)
      && !resp.push_pc && resp.instr == $past(data_in)
      && resp.trap == $past(undefined_op);
  endproperty
  a_instr: assert property (p_instr)
    else $error("bad instruction response");
  property p_rst;
    resp.valid && resp.kind == VIR_KIND_RST |-> resp.push_pc
      && resp.addr == 16'h0038;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad restart response");
  property p_vec_push;
    resp.valid && resp.kind == VIR_KIND_VEC |-> resp.push_pc;
  endproperty
  a_vec_push: assert property (p_vec_push)
    else $error("vector response without push");
  property p_hold;
    resp.valid && !resp_taken |=> resp.valid && $stable(resp.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("response dropped before taken");

  c_wait: cover property ($rose(auto_wait_state));
  c_rst: cover property (resp.valid && resp.kind == VIR_KIND_RST);
  c_trap: cover property ($rose(resp.valid) && resp.trap);
endmodule : vir_core_chk

bind vir_core vir_core_chk u_chk (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .t3_rise, .data_in, .undefined_op, .resp_taken,
  .opcode_fetch_strobe_n, .io_request_strobe_n, .auto_wait_state, .resp);

// >>> test/vir_dev_model.sv
// Interrupting device that answers acknowledge cycles
`timescale 1ns/1ps
module vir_dev_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       fetch_n,
  input  wire logic       ioreq_n,
  input  wire logic       waiting,
  input  wire logic [1:0] delay,
  input  wire logic [7:0] vec_byte,
  input  wire logic       bad,
  output logic            t3_rise,
  output logic [7:0]      data_out,
  output logic            undef
);
  logic [2:0] cnt;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt      <= 3'h0;
      t3_rise  <= 1'b0;
      data_out <= 8'h00;
      undef    <= 1'b0;
    end else begin
      t3_rise  <= 1'b0;
      undef    <= 1'b0;
      data_out <= ~data_out;
      if (fetch_n || ioreq_n) cnt <= 3'h0;
      else if (!waiting) cnt <= cnt + 3'h1;
      if (!fetch_n && !waiting && cnt == {1'b0, delay} + 3'h1) begin
        t3_rise  <= 1'b1;
        data_out <= vec_byte;
        undef    <= bad;
      end
    end
  end
endmodule : vir_dev_model
